//--- rtl/ebp_pkg.sv
// package of constants and carrier types for the eight-bit io port
`default_nettype none

package ebp_pkg;

    localparam int unsigned NUM_PINS       = 8;
    localparam int unsigned INPUT_ONLY_PIN = 3;

    localparam logic [7:0] INPUT_ONLY_MASK = 8'h08;
    localparam logic [7:0] DIR_RESET       = 8'hff;
    localparam logic [7:0] LATCH_RESET     = 8'h00;
    localparam logic [7:0] OPEN_DRAIN_RESET = 8'h00;
    localparam logic [7:0] SLEW_RESET      = 8'h00;
    localparam logic [7:0] LEVEL_RESET     = 8'h00;
    localparam logic [7:0] ALL_ZERO        = 8'h00;

    // level select bit value: 1 picks Schmitt CMOS, 0 picks TTL
    localparam logic LEVEL_CMOS = 1'b1;

    typedef enum logic [2:0] {
        SEL_DATA,
        SEL_DIR,
        SEL_OPEN_DRAIN,
        SEL_SLEW,
        SEL_LEVEL
    } ebp_reg_sel_t;

    typedef struct packed {
        logic         valid;
        ebp_reg_sel_t sel;
        logic [7:0]   mask;
        logic [7:0]   data;
    } ebp_wr_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] slewLimit;
    } ebp_pad_drive_t;

endpackage

`default_nettype wire

//--- rtl/ebp_pin_cell.sv
// one pin: driver enable, open-drain, slew and input threshold selection
`default_nettype none

module ebp_pin_cell #(
    parameter bit INPUT_ONLY = 1'b0
) (
    input  wire logic dirIn,
    input  wire logic latchBit,
    input  wire logic openDrainSel,
    input  wire logic slewSel,
    input  wire logic levelSel,
    input  wire logic analogSel,
    input  wire logic padInCmos,
    input  wire logic padInTtl,
    output logic      padOut,
    output logic      padOe,
    output logic      padSlewLimit,
    output logic      levelRead
);

    ////////////////////////////////////////////////////////////////////////////
    // drive side
    // the analog select never enters the enable: direction, with the open-drain select and latch bit, owns the driver
    always_comb begin
        if (INPUT_ONLY) begin
            padOe = 1'b0;
        end else if (dirIn) begin
            padOe = 1'b0;
        end else if (openDrainSel) begin
            padOe = ~latchBit;
        end else begin
            padOe = 1'b1;
        end
    end

    // open drain only ever pulls low, so the driven value is then fixed at zero
    assign padOut       = openDrainSel ? 1'b0 : latchBit;
    assign padSlewLimit = slewSel;

    ////////////////////////////////////////////////////////////////////////////
    // sense side
    always_comb begin
        if (analogSel) begin
            levelRead = 1'b0;
        end else if (levelSel == ebp_pkg::LEVEL_CMOS) begin
            levelRead = padInCmos;
        end else begin
            levelRead = padInTtl;
        end
    end

endmodule // ebp_pin_cell

`default_nettype wire

//--- rtl/ebp_io_port.sv
// eight-bit general purpose io port with per-pin drive and threshold control
//
// Functional notes
// - pin 3 is input only and doubles as master clear, which config may disable.
// - direction bit of pin 3 always reads back as one.
// - seven bidirectional pins plus input-only pin 3, each with its own direction bit.
// - direction bit one puts the pin driver in high impedance.
// - direction bit zero enables the driver with the output latch value.
// - data read returns pin levels; data write goes to the output latch.
// - every data write is read-modify-write on the pin levels.
// - direction bits control drivers even for analog input pins.
// - analog input pins always read as zero.
// - open-drain select set makes the output sink only.
// - open-drain select clear makes the output push-pull.
// - per-pin slew select limits slew when set, full rate when clear.
// - per-pin threshold select, CMOS or TTL, governs reads.
`default_nettype none

module ebp_io_port (
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    input  wire ebp_pkg::ebp_wr_req_t   wrReq,
    input  wire logic [7:0]             analogSel,
    input  wire logic                   mclrEnable,
    input  wire logic [7:0]             padInCmos,
    input  wire logic [7:0]             padInTtl,
    output ebp_pkg::ebp_pad_drive_t     padDrive,
    output logic [7:0]                  portRead,
    output logic [7:0]                  dirRead,
    output logic [7:0]                  latchRead,
    output logic [7:0]                  openDrainRead,
    output logic [7:0]                  slewRead,
    output logic [7:0]                  levelSelRead,
    output logic                        masterClearReq,
    output logic [7:0]                  pinLevel
);

    ////////////////////////////////////////////////////////////////////////////
    // register state

    logic [7:0] direction;
    logic [7:0] outLatch;
    logic [7:0] openDrain;
    logic [7:0] slewLimit;
    logic [7:0] levelSel;

    logic [7:0] next_direction;
    logic [7:0] next_outLatch;

    ////////////////////////////////////////////////////////////////////////////
    // assertion defaults: one clock domain, checks idle while reset is high

    default clocking cb @(posedge ref_clk);
    endclocking

    default disable iff (rst);

    // masked merge used by every write target
    function automatic logic [7:0] merge(
        input logic [7:0] oldVal,
        input logic [7:0] newVal,
        input logic [7:0] mask
    );
        merge = (oldVal & ~mask) | (newVal & mask);
    endfunction

    function automatic logic hits(
        input ebp_pkg::ebp_wr_req_t req,
        input ebp_pkg::ebp_reg_sel_t sel
    );
        hits = req.valid && (req.sel == sel);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // direction register

    always_comb begin
        next_direction = direction;
        if (hits(wrReq, ebp_pkg::SEL_DIR)) begin
            next_direction = merge(direction, wrReq.data, wrReq.mask);
        end
        // writes to the input-only pin's bit are dropped so readback stays one
        next_direction = next_direction | ebp_pkg::INPUT_ONLY_MASK;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            direction <= ebp_pkg::DIR_RESET;
        end else begin
            direction <= next_direction;
        end
    end

    // pin 3 must never become an output, whatever software writes
    dir_pin3_set_a: assert property (
        dirRead[ebp_pkg::INPUT_ONLY_PIN] == 1'b1
    ) else $error("direction bit of the input-only pin reads back as zero");

    dir_after_reset_a: assert property (
        $fell(rst) |-> dirRead == ebp_pkg::DIR_RESET
    ) else $error("direction bits not all set after reset");

    dir_write_a: assert property (
        hits(wrReq, ebp_pkg::SEL_DIR)
        |=> dirRead == (merge($past(dirRead), $past(wrReq.data), $past(wrReq.mask))
                        | ebp_pkg::INPUT_ONLY_MASK)
    ) else $error("direction register did not take the masked write");

    dir_hold_a: assert property (
        !hits(wrReq, ebp_pkg::SEL_DIR) |=> $stable(dirRead)
    ) else $error("direction register changed without a write");

    ////////////////////////////////////////////////////////////////////////////
    // output latch, written read-modify-write from the pin levels

    // the merge starts from the last sampled pin levels, not from the latch:
    // a pin held low by an outside load can flip its latch bit on an unrelated write
    always_comb begin
        next_outLatch = outLatch;
        if (hits(wrReq, ebp_pkg::SEL_DATA)) begin
            next_outLatch = merge(portRead, wrReq.data, wrReq.mask);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            outLatch <= ebp_pkg::LATCH_RESET;
        end else begin
            outLatch <= next_outLatch;
        end
    end

    latch_rmw_a: assert property (
        hits(wrReq, ebp_pkg::SEL_DATA)
        |=> latchRead == merge($past(portRead), $past(wrReq.data), $past(wrReq.mask))
    ) else $error("output latch not rebuilt from the sampled pin levels");

    // the pins never load the latch directly; only a data write may change it
    latch_hold_a: assert property (
        !hits(wrReq, ebp_pkg::SEL_DATA) |=> $stable(latchRead)
    ) else $error("output latch changed without a data write");

    ////////////////////////////////////////////////////////////////////////////
    // drive option and threshold select registers

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            openDrain <= ebp_pkg::OPEN_DRAIN_RESET;
        end else if (hits(wrReq, ebp_pkg::SEL_OPEN_DRAIN)) begin
            openDrain <= merge(openDrain, wrReq.data, wrReq.mask);
        end
    end

    // a write lands on the next edge and touches only the masked bits
    od_write_a: assert property (
        hits(wrReq, ebp_pkg::SEL_OPEN_DRAIN)
        |=> openDrainRead == merge($past(openDrainRead), $past(wrReq.data),
                                   $past(wrReq.mask))
    ) else $error("open-drain selects did not take the masked write");

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            slewLimit <= ebp_pkg::SLEW_RESET;
        end else if (hits(wrReq, ebp_pkg::SEL_SLEW)) begin
            slewLimit <= merge(slewLimit, wrReq.data, wrReq.mask);
        end
    end

    slew_write_a: assert property (
        hits(wrReq, ebp_pkg::SEL_SLEW)
        |=> slewRead == merge($past(slewRead), $past(wrReq.data), $past(wrReq.mask))
    ) else $error("slew selects did not take the masked write");

    // a threshold change can glitch the selected level for one sample;
    // nothing here filters it, so software must change it with peripherals idle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            levelSel <= ebp_pkg::LEVEL_RESET;
        end else if (hits(wrReq, ebp_pkg::SEL_LEVEL)) begin
            levelSel <= merge(levelSel, wrReq.data, wrReq.mask);
        end
    end

    level_write_a: assert property (
        hits(wrReq, ebp_pkg::SEL_LEVEL)
        |=> levelSelRead == merge($past(levelSelRead), $past(wrReq.data), $past(wrReq.mask))
    ) else $error("threshold selects did not take the masked write");

    ////////////////////////////////////////////////////////////////////////////
    // pin cells

    genvar gi;
    generate
        for (gi = 0; gi < ebp_pkg::NUM_PINS; gi++) begin : g_pin
            ebp_pin_cell #(
                .INPUT_ONLY (gi == ebp_pkg::INPUT_ONLY_PIN)
            ) u_cell (
                .dirIn        (direction[gi]),
                .latchBit     (outLatch[gi]),
                .openDrainSel (openDrain[gi]),
                .slewSel      (slewLimit[gi]),
                .levelSel     (levelSel[gi]),
                .analogSel    (analogSel[gi]),
                .padInCmos    (padInCmos[gi]),
                .padInTtl     (padInTtl[gi]),
                .padOut       (padDrive.out[gi]),
                .padOe        (padDrive.oe[gi]),
                .padSlewLimit (padDrive.slewLimit[gi]),
                .levelRead    (pinLevel[gi])
            );
        end
    endgenerate

    // the per-pin checks name their clock and reset, as they sit in a generate scope
    generate
        for (gi = 0; gi < ebp_pkg::NUM_PINS; gi++) begin : g_pin_chk
            threshold_pick_a: assert property (
                @(posedge ref_clk) disable iff (rst)
                !analogSel[gi] |-> pinLevel[gi] == ((levelSel[gi] == ebp_pkg::LEVEL_CMOS)
                                                    ? padInCmos[gi] : padInTtl[gi])
            ) else $error("pin read does not follow its threshold select");

            slew_pass_a: assert property (
                @(posedge ref_clk) disable iff (rst)
                padDrive.slewLimit[gi] == slewLimit[gi]
            ) else $error("slew select not passed to its pin");
        end
    endgenerate

    pin3_undriven_a: assert property (
        !padDrive.oe[ebp_pkg::INPUT_ONLY_PIN]
    ) else $error("input-only pin has its driver enabled");

    input_hiz_a: assert property (
        (padDrive.oe & dirRead) == ebp_pkg::ALL_ZERO
    ) else $error("a pin set as input has its driver enabled");

    push_pull_a: assert property (
        ((~padDrive.oe | (padDrive.out ^ latchRead)) & ~dirRead & ~openDrainRead)
            == ebp_pkg::ALL_ZERO
    ) else $error("push-pull output not driving its latch value");

    // an open-drain pin may pull low, but must never push a one onto the line
    od_sink_only_a: assert property (
        (padDrive.oe & padDrive.out & openDrainRead) == ebp_pkg::ALL_ZERO
    ) else $error("open-drain pin drove a one");

    od_pull_low_a: assert property (
        ((padDrive.oe ^ ~latchRead) & ~dirRead & openDrainRead) == ebp_pkg::ALL_ZERO
    ) else $error("open-drain pin not pulling low for a zero in its latch");

    // analog use must not take the driver away from the direction bit
    analog_drive_a: assert property (
        (~padDrive.oe & ~dirRead & ~openDrainRead & analogSel) == ebp_pkg::ALL_ZERO
    ) else $error("analog select disabled a driver the direction bit enabled");

    ////////////////////////////////////////////////////////////////////////////
    // read side and master clear

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            portRead <= ebp_pkg::ALL_ZERO;
        end else begin
            portRead <= pinLevel;
        end
    end

    // master clear pin is active low; with the function disabled it is a plain input
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            masterClearReq <= 1'b0;
        end else begin
            masterClearReq <= mclrEnable && !pinLevel[ebp_pkg::INPUT_ONLY_PIN];
        end
    end

    assign dirRead       = direction;
    assign latchRead     = outLatch;
    assign openDrainRead = openDrain;
    assign slewRead      = slewLimit;
    assign levelSelRead  = levelSel;

    // a read shows the pins as they stood one clock earlier, never the latch
    port_read_a: assert property (
        !$past(rst) |-> portRead == $past(pinLevel)
    ) else $error("port read does not show the last sampled pin levels");

    analog_zero_a: assert property (
        (pinLevel & analogSel) == ebp_pkg::ALL_ZERO
    ) else $error("analog pin did not read as zero");

    master_clear_input_follow_a: assert property (
        !$past(rst) |-> masterClearReq == ($past(mclrEnable)
            && !$past(pinLevel[ebp_pkg::INPUT_ONLY_PIN]))
    ) else $error("master clear request does not follow the pin");

    master_clear_input_off_a: assert property (
        !mclrEnable |=> !masterClearReq
    ) else $error("master clear requested while the function is disabled");

endmodule // ebp_io_port

`default_nettype wire

//--- verif/ebp_pin_model.sv
// far-side model: the external circuit on each pin, merged with the port's drivers
`default_nettype none

module ebp_pin_model (
    input  wire ebp_pkg::ebp_pad_drive_t padDrive,
    input  wire logic [7:0]              extCmos,
    input  wire logic [7:0]              extTtl,
    output logic [7:0]                   padInCmos,
    output logic [7:0]                   padInTtl
);
    timeunit 1ns;
    timeprecision 1ns;

    // a driven pin shows its driver at both thresholds, a released one the outside level
    assign padInCmos = (padDrive.oe & padDrive.out) | (~padDrive.oe & extCmos);
    assign padInTtl  = (padDrive.oe & padDrive.out) | (~padDrive.oe & extTtl);
endmodule // ebp_pin_model

`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the eight-bit io port
`default_nettype none

`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                    ref_clk;
    logic                    rst;
    ebp_pkg::ebp_wr_req_t    wrReq;
    logic [7:0]              analogSel;
    logic                    mclrEnable;
    logic [7:0]              padInCmos;
    logic [7:0]              padInTtl;
    logic [7:0]              extCmos;
    logic [7:0]              extTtl;
    ebp_pkg::ebp_pad_drive_t padDrive;
    logic [7:0]              portRead;
    logic [7:0]              dirRead;
    logic [7:0]              latchRead;
    logic [7:0]              openDrainRead;
    logic [7:0]              slewRead;
    logic [7:0]              levelSelRead;
    logic                    masterClearReq;
    logic [7:0]              pinLevel;
    int                      miscompares;
    int                      nCompared;

    ebp_io_port i_ebp_io_port (
        .ref_clk(ref_clk), .rst(rst), .wrReq(wrReq), .analogSel(analogSel),
        .mclrEnable(mclrEnable), .padInCmos(padInCmos), .padInTtl(padInTtl),
        .padDrive(padDrive), .portRead(portRead), .dirRead(dirRead), .latchRead(latchRead),
        .openDrainRead(openDrainRead), .slewRead(slewRead), .levelSelRead(levelSelRead),
        .masterClearReq(masterClearReq), .pinLevel(pinLevel)
    );

    ebp_pin_model i_ebp_pin_model (
        .padDrive(padDrive), .extCmos(extCmos), .extTtl(extTtl),
        .padInCmos(padInCmos), .padInTtl(padInTtl)
    );

    always #12.5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////

    task automatic report_and_stop();
        if (miscompares == 0 && nCompared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one-cycle write request, then one spare cycle so every readback has settled
    task automatic wr(input ebp_pkg::ebp_reg_sel_t sel, input logic [7:0] mask,
                      input logic [7:0] data);
        @(negedge ref_clk);
        wrReq = '{valid: 1'b1, sel: sel, mask: mask, data: data};
        @(negedge ref_clk);
        wrReq.valid = 1'b0;
        @(negedge ref_clk);
    endtask

    initial begin
        #(25ns * 2000);
        miscompares++;
        report_and_stop();
    end

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        wrReq = '0;
        analogSel = 8'h00;
        mclrEnable = 1'b0;
        extCmos = 8'h5a;
        extTtl = 8'ha5;
        miscompares = 0;
        nCompared = 0;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        @(negedge ref_clk);
        `CHK("dir", 8'hff, dirRead)
        `CHK("oe", 8'h00, padDrive.oe)
        `CHK("portTtl", 8'ha5, portRead)
        // threshold changed with no peripheral running
        wr(ebp_pkg::SEL_LEVEL, 8'hff, 8'hff);
        `CHK("levelSel", 8'hff, levelSelRead)
        `CHK("portCmos", 8'h5a, portRead)
        // unmasked bits take the pin levels, not the old latch
        wr(ebp_pkg::SEL_DATA, 8'h01, 8'h01);
        `CHK("latch", 8'h5b, latchRead)
        `CHK("oeIn", 8'h00, padDrive.oe)
        // analog pins kept as inputs, the usual setup
        analogSel = 8'hff;
        @(negedge ref_clk);
        `CHK("pinAnalog", 8'h00, pinLevel)
        `CHK("portAnalogIn", 8'h00, portRead)
        `CHK("oeAnalogIn", 8'h00, padDrive.oe)
        analogSel = 8'h00;
        wr(ebp_pkg::SEL_DIR, 8'hff, 8'h00);
        `CHK("dirPin3", 8'h08, dirRead)
        `CHK("oeOut", 8'hf7, padDrive.oe)
        `CHK("outDrv", 8'h53, padDrive.out & 8'hf7)
        `CHK("portDrv", 8'h5b, portRead)
        wr(ebp_pkg::SEL_OPEN_DRAIN, 8'hff, 8'hff);
        `CHK("odRead", 8'hff, openDrainRead)
        `CHK("oeOd", 8'ha4, padDrive.oe)
        wr(ebp_pkg::SEL_OPEN_DRAIN, 8'hff, 8'h00);
        `CHK("oePp", 8'hf7, padDrive.oe)
        // analog with outputs enabled breaks the usual setup on purpose
        analogSel = 8'hff;
        @(negedge ref_clk);
        @(negedge ref_clk);
        `CHK("portAnalog", 8'h00, portRead)
        `CHK("oeAnalog", 8'hf7, padDrive.oe)
        analogSel = 8'h00;
        wr(ebp_pkg::SEL_SLEW, 8'hff, 8'h3c);
        `CHK("slewRead", 8'h3c, slewRead)
        `CHK("slewDrv", 8'h3c, padDrive.slewLimit)
        extCmos = 8'h00;
        @(negedge ref_clk);
        @(negedge ref_clk);
        `CHK("mclrOff", 1'b0, masterClearReq)
        `CHK("pin3In", 8'h00, portRead & 8'h08)
        mclrEnable = 1'b1;
        @(negedge ref_clk);
        `CHK("mclrLow", 1'b1, masterClearReq)
        extCmos = 8'h08;
        @(negedge ref_clk);
        `CHK("mclrHigh", 1'b0, masterClearReq)
        `CHK("pinLevel", 8'h5b, pinLevel)
        // second reset in mid-run brings every pin back to an undriven input
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        `CHK("dirRst", 8'hff, dirRead)
        `CHK("oeRst", 8'h00, padDrive.oe)
        @(negedge ref_clk);
        `CHK("portRst", 8'ha5, portRead)
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
